// File: bench/event_source.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External pulse source and slow oscillator
// ----------------------------------------
module event_source (
  // Clock
  input wire logic clock,
  // Pins toward the device
  output logic ev0,
  output logic ev1,
  output logic slow
);
  // The 32768 Hz crystal runs free, unrelated in phase to the system clock
  initial begin
    slow = 1'b0;
    #7;
    forever #15259 slow = ~slow;
  end
  initial begin
    ev0 = 1'b0;
    ev1 = 1'b0;
  end
  // Levels change just after an edge and are held, so no edge is a glitch
  task automatic drive(input int ch, input logic v);
    @(posedge clock);
    if (ch == 0) ev0 <= v;
    else ev1 <= v;
  endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import tec_pkg::*;
;
  logic clock, reset, pin_in, pin_q, e;
  avalon_req_t req;
  avalon_rsp_t rsp;
  wire logic ev0, ev1, slow, pin_out, pin_oe, wake, irq, pwm;
  int errors, tests_run, wakes, edges, p;
  logic [7:0] rd;
  logic [15:0] v, v2;
  logic [7:0] pa [2] = '{8'h0D, 8'h04};
  // ----------------------------------------
  // Clock, device, far side
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  timer_event_counter_with_freq_divider dut (.clock(clock), .reset(reset), .bus_req(req),
    .bus_rsp(rsp), .cnt0_event_input(ev0), .cnt1_event_input(ev1), .slow_clock_32k(slow),
    .port_a_bit3_in(pin_in), .port_a_bit3_out(pin_out), .port_a_bit3_oe(pin_oe),
    .wake_up(wake), .irq_request(irq), .pwm_clock_tick(pwm));
  event_source src (.clock(clock), .ev0(ev0), .ev1(ev1), .slow(slow));
  always @(posedge clock) begin
    if (wake === 1'b1) wakes++;
    if (pin_out !== pin_q) edges++;
    pin_q = pin_out;
  end
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [7:0] d);
    int n;
    @(posedge clock);
    req <= '{read: !wr, write: wr, address: {idx, 2'h0}, writedata: {24'h0, wd},
             byteenable: 4'hF};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 50);
    if (n >= 50) errors++;
    d = rsp.readdata[7:0];
    req <= '0;
  endtask
  task automatic wr8(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] x;
    xfer(1'b1, idx, d, x);
  endtask
  task automatic rd8(input logic [5:0] idx, output logic [7:0] d);
    xfer(1'b0, idx, 8'h00, d);
  endtask
  // Low byte first: the high write commits the pair
  task automatic load(input logic [5:0] hi, input logic [15:0] d);
    wr8(hi + 6'h01, d[7:0]);
    wr8(hi, d[15:8]);
  endtask
  task automatic rd16(input logic [5:0] hi, output logic [15:0] d);
    rd8(hi, d[15:8]);
    rd8(hi + 6'h01, d[7:0]);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic pulse(input int ch, input logic act, input int n);
    src.drive(ch, act);
    waitc(n);
    src.drive(ch, ~act);
    waitc(8);
  endtask
  function automatic int ticks(input int cycles, input int code);
    return cycles >> code;
  endfunction
  // Sync stages and prescaler phase make a tolerance unavoidable here
  function automatic logic near(input logic [15:0] x, input int exp, input int tol);
    return (int'(x) >= exp - tol) && (int'(x) <= exp + tol);
  endfunction
  task automatic report_and_stop;
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(40 * 30000);
    errors++;
    report_and_stop();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    req = '0;
    pin_in = 1'b0;
    reset = 1'b1;
    void'($urandom(96));
    waitc(2);
    reset <= 1'b0;
    rd8(IDX_PORT_A_CONTROL, rd);
    check(rd, {4'h0, PA_RESET});
    rd8(6'h20, rd);
    check(rd, 8'h00);
    wr8(IDX_CNT1_CONTROL, 8'h2F);
    rd8(IDX_CNT1_CONTROL, rd);
    check(rd, 8'h28);
    wr8(IDX_CNT0_CONTROL, 8'h27);
    rd8(IDX_CNT0_CONTROL, rd);
    check(rd, 8'h07);
    v2 = 16'($urandom);
    load(IDX_CNT0_HIGH, v2);
    rd16(IDX_CNT0_HIGH, v);
    check(v, v2);
    for (int c = 0; c < 8; c++) begin
      load(IDX_CNT0_HIGH, 16'h0000);
      wr8(IDX_CNT0_CONTROL, {MODE_TIMER, 3'h2, c[2:0]});
      p = 0;
      repeat (256) begin
        @(posedge clock);
        if (pwm === 1'b1) p++;
      end
      wr8(IDX_CNT0_CONTROL, {MODE_TIMER, 3'h0, c[2:0]});
      check(p, ticks(256, c));
      rd16(IDX_CNT0_HIGH, v);
      check(near(v, ticks(259, c), 2), 1'b1);
    end
    load(IDX_CNT0_HIGH, 16'hFF80);
    wr8(IDX_PORT_A_CONTROL, 8'h05);
    wr8(IDX_CNT0_CONTROL, 8'h90);
    load(IDX_CNT0_HIGH, 16'hFFC0);
    rd16(IDX_CNT0_HIGH, v);
    check(v[15:6], 10'h3FE);
    waitc(90);
    rd16(IDX_CNT0_HIGH, v);
    check(v[15:6], 10'h3FF);
    wakes = 0;
    edges = 0;
    waitc(640);
    check(near(wakes[15:0], 10, 1), 1'b1);
    check(near(edges[15:0], wakes, 1), 1'b1);
    check(pin_oe, 1'b1);
    rd8(IDX_IRQ_CONTROL0, rd);
    check(rd, 8'h40);
    check(irq, 1'b0);
    wr8(IDX_IRQ_CONTROL0, 8'h41);
    waitc(3);
    check(irq, 1'b1);
    rd8(IDX_CNT0_CONTROL, rd);
    check(rd, 8'h90);
    wr8(IDX_IRQ_CONTROL0, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr8(IDX_PORT_A_CONTROL, pa[k]);
      waitc(3);
      edges = 0;
      waitc(200);
      check(edges, 0);
    end
    check(pin_out, 1'b0);
    for (int k = 0; k < 2; k++) begin
      pin_in <= k[0] ^ 1'($urandom);
      wr8(IDX_PORT_A_CONTROL, 8'h06);
      waitc(4);
      rd8(IDX_PORT_A_CONTROL, rd);
      check(rd[4], pin_in);
      check(pin_oe, 1'b0);
    end
    // Counter 0 still runs as a timer here: stop it so the load reaches the count
    wr8(IDX_CNT0_CONTROL, 8'h40);
    load(IDX_CNT0_HIGH, 16'h0000);
    wr8(IDX_CNT0_CONTROL, 8'h50);
    p = $urandom_range(3, 9);
    repeat (p) pulse(0, 1'b1, 6);
    wr8(IDX_CNT0_CONTROL, 8'h40);
    rd16(IDX_CNT0_HIGH, v);
    check(v, p[15:0]);
    for (int k = 0; k < 2; k++) begin
      e = k[0];
      load(IDX_CNT1_HIGH, 16'h0000);
      wr8(IDX_CNT1_CONTROL, {MODE_EVENT, 2'h1, e, 3'h0});
      src.drive(1, 1'b1);
      waitc(8);
      rd16(IDX_CNT1_HIGH, v);
      check(v, {15'h0, ~e});
      src.drive(1, 1'b0);
      waitc(8);
      rd16(IDX_CNT1_HIGH, v);
      check(v, 16'h0001);
      wr8(IDX_CNT1_CONTROL, {MODE_EVENT, 2'h0, e, 3'h0});
      pulse(1, 1'b1, 8);
      rd16(IDX_CNT1_HIGH, v);
      check(v, 16'h0001);
    end
    for (int k = 0; k < 2; k++) begin
      e = k[0];
      src.drive(1, ~e);
      waitc(8);
      load(IDX_CNT1_HIGH, 16'h0000);
      wr8(IDX_CNT1_CONTROL, {MODE_PULSE, 2'h1, e, 3'h0});
      p = $urandom_range(40, 120);
      pulse(1, e, p);
      rd8(IDX_CNT1_CONTROL, rd);
      check(rd, {MODE_PULSE, 2'h0, e, 3'h0});
      rd16(IDX_CNT1_HIGH, v);
      check(near(v, p / 4, 2), 1'b1);
      pulse(1, e, 40);
      rd16(IDX_CNT1_HIGH, v2);
      check(v2, v);
    end
    load(IDX_CNT1_HIGH, 16'h0000);
    wr8(IDX_CNT1_CONTROL, 8'hB0);
    waitc(3052);
    wr8(IDX_CNT1_CONTROL, 8'hA0);
    rd16(IDX_CNT1_HIGH, v);
    check(near(v, 4, 1), 1'b1);
    load(IDX_CNT1_HIGH, 16'hFFF8);
    wr8(IDX_CNT1_CONTROL, 8'h90);
    waitc(40);
    wr8(IDX_CNT1_CONTROL, 8'h80);
    rd8(IDX_SECOND_IRQ_CONTROL, rd);
    check(rd, 8'h10);
    check(irq, 1'b0);
    wr8(IDX_SECOND_IRQ_CONTROL, 8'h11);
    waitc(3);
    check(irq, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: rtl/tec_pkg.sv
package tec_pkg;

  // ----------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------
  localparam logic [5:0] IDX_CNT0_HIGH = 6'h0C;
  localparam logic [5:0] IDX_CNT0_LOW = 6'h0D;
  localparam logic [5:0] IDX_CNT0_CONTROL = 6'h0E;
  localparam logic [5:0] IDX_CNT1_HIGH = 6'h0F;
  localparam logic [5:0] IDX_CNT1_LOW = 6'h10;
  localparam logic [5:0] IDX_CNT1_CONTROL = 6'h11;
  localparam logic [5:0] IDX_IRQ_CONTROL0 = 6'h12;
  localparam logic [5:0] IDX_SECOND_IRQ_CONTROL = 6'h13;
  localparam logic [5:0] IDX_PORT_A_CONTROL = 6'h14;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTL_PSC_LSB = 0;
  localparam int CTL_EDGE = 3;
  localparam int CTL_RUN = 4;
  localparam int CTL_CLKSEL = 5;
  localparam int CTL_MODE_LSB = 6;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_PULSE = 2'h3;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ----------------------------------------
  // Interrupt and port fields
  // ----------------------------------------
  localparam int IRQ_EN_BIT = 0;
  localparam int IRQ0_FLAG_BIT = 6;
  localparam int IRQ1_FLAG_BIT = 4;
  localparam int PA_LATCH = 0;
  localparam int PA_INPUT = 1;
  localparam int PA_PFD_EN = 2;
  localparam int PA_PFD_SRC = 3;
  localparam int PA_PIN = 4;
  localparam logic [3:0] PA_RESET = 4'h2;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam int PSC_W = 7;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    PW_ARM = 3'b001,
    PW_COUNT = 3'b010,
    PW_HOLD = 3'b100
  } pulse_state_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avalon_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avalon_rsp_t;

endpackage

// File: rtl/timer_event_counter_with_freq_divider.sv
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// One 16-bit count-up unit
// ----------------------------------------
module timer_unit
  import tec_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Count sources
  input wire logic tick,
  input wire logic event_sync,
  // Configuration
  input wire logic edge_sel,
  input wire logic run,
  input wire logic [1:0] mode,
  input wire logic freeze,
  // Loading
  input wire logic load,
  input wire logic [15:0] load_value,
  input wire logic [15:0] preload,
  // Results
  output logic [15:0] count,
  output logic overflow,
  output logic measure_done
);
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic ev_prev_r;
  pulse_state_t state_r;
  pulse_state_t state_nxt;

  wire rise = event_sync & ~ev_prev_r;
  wire fall = ~event_sync & ev_prev_r;
  wire act_edge = edge_sel ? fall : rise;
  wire start_edge = edge_sel ? rise : fall;
  wire stop_edge = edge_sel ? fall : rise;
  wire is_pulse = (mode == MODE_PULSE);
  wire pulse_step = (state_r == PW_COUNT) & tick & ~stop_edge;
  wire mode_step = (mode == MODE_EVENT) ? act_edge :
                   (mode == MODE_TIMER) ? tick :
                   is_pulse ? pulse_step : 1'b0;
  // High-byte reads stall the count; lost steps are accepted
  wire step = run & ~freeze & mode_step;

  assign overflow = step & (count_r == COUNT_MAX);
  assign measure_done = (state_r == PW_COUNT) & run & is_pulse & stop_edge;
  assign count = count_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PW_ARM: begin
        if (run && is_pulse && start_edge) begin
          state_nxt = PW_COUNT;
        end
      end
      PW_COUNT: begin
        if (!run || !is_pulse) begin
          state_nxt = PW_ARM;
        end else if (stop_edge) begin
          state_nxt = PW_HOLD;
        end
      end
      PW_HOLD: begin
        if (!run) begin
          state_nxt = PW_ARM;
        end
      end
      default: state_nxt = PW_ARM;
    endcase
  end

  always_comb begin
    if (load) begin
      count_nxt = load_value;
    end else if (overflow) begin
      count_nxt = preload;
    end else if (step) begin
      count_nxt = 16'(count_r + 16'h0001);
    end else begin
      count_nxt = count_r;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_r <= COUNT_RESET;
      ev_prev_r <= 1'b0;
      state_r <= PW_ARM;
    end else begin
      count_r <= count_nxt;
      ev_prev_r <= event_sync;
      state_r <= state_nxt;
    end
  end
endmodule

// ----------------------------------------
// Top: two counters, prescaler, divider pin
// ----------------------------------------
module timer_event_counter_with_freq_divider
  import tec_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register bus
  input wire avalon_req_t bus_req,
  output avalon_rsp_t bus_rsp,
  // External count pins and slow clock
  input wire logic cnt0_event_input,
  input wire logic cnt1_event_input,
  input wire logic slow_clock_32k,
  // Shared port pin
  input wire logic port_a_bit3_in,
  output logic port_a_bit3_out,
  output logic port_a_bit3_oe,
  // System events
  output logic wake_up,
  output logic irq_request,
  output logic pwm_clock_tick
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic slow_prev_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      slow_prev_r <= 1'b0;
    end else begin
      sync1_r <= {port_a_bit3_in, slow_clock_32k, cnt1_event_input, cnt0_event_input};
      sync2_r <= sync1_r;
      slow_prev_r <= sync2_r[2];
    end
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  avalon_rsp_t rsp_r;
  logic [7:0] ctl0_r;
  logic [7:0] ctl1_r;
  logic [7:0] low_buf0_r;
  logic [7:0] low_buf1_r;
  logic [15:0] preload0_r;
  logic [15:0] preload1_r;
  logic irq0_en_r;
  logic irq1_en_r;
  logic flag0_r;
  logic flag1_r;
  logic [3:0] port_r;
  logic pfd_r;
  logic pin_out_r;
  logic pin_oe_r;
  logic wake_r;
  logic irq_r;
  logic pwm_tick_r;
  logic [PSC_W-1:0] psc_r;
  logic [15:0] count0;
  logic [15:0] count1;
  logic ovf0;
  logic ovf1;
  logic done0;
  logic done1;

  wire [5:0] idx = bus_req.address[7:2];
  wire aligned = (bus_req.address[1:0] == 2'h0);
  wire acc_go = (bus_req.read | bus_req.write) & rsp_r.waitrequest;
  wire wr_go = acc_go & bus_req.write & bus_req.byteenable[0] & aligned;
  wire rd_go = acc_go & bus_req.read;
  wire [7:0] wdata = bus_req.writedata[7:0];
  wire wr_hi0 = wr_go & (idx == IDX_CNT0_HIGH);
  wire wr_lo0 = wr_go & (idx == IDX_CNT0_LOW);
  wire wr_ctl0 = wr_go & (idx == IDX_CNT0_CONTROL);
  wire wr_hi1 = wr_go & (idx == IDX_CNT1_HIGH);
  wire wr_lo1 = wr_go & (idx == IDX_CNT1_LOW);
  wire wr_ctl1 = wr_go & (idx == IDX_CNT1_CONTROL);
  wire wr_irq0 = wr_go & (idx == IDX_IRQ_CONTROL0);
  wire wr_irq1 = wr_go & (idx == IDX_SECOND_IRQ_CONTROL);
  wire wr_port = wr_go & (idx == IDX_PORT_A_CONTROL);
  wire rd_hi0 = rd_go & aligned & (idx == IDX_CNT0_HIGH);
  wire rd_hi1 = rd_go & aligned & (idx == IDX_CNT1_HIGH);
  wire run0 = ctl0_r[CTL_RUN];
  wire run1 = ctl1_r[CTL_RUN];
  wire load0 = wr_hi0 & ~run0;
  wire load1 = wr_hi1 & ~run1;

  // ----------------------------------------
  // Prescaler and clock sources
  // ----------------------------------------
  wire [2:0] psc_sel = ctl0_r[CTL_PSC_LSB +: 3];
  wire [PSC_W-1:0] psc_mask = PSC_W'((8'h01 << psc_sel) - 8'h01);
  wire tick0 = ((psc_r & psc_mask) == psc_mask);
  wire slow_rise = sync2_r[2] & ~slow_prev_r;
  wire tick1 = ctl1_r[CTL_CLKSEL] ? slow_rise : (psc_r[1:0] == DIV4_LAST);

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  timer_unit u_cnt0 (
    .clock(clock),
    .reset(reset),
    .tick(tick0),
    .event_sync(sync2_r[0]),
    .edge_sel(ctl0_r[CTL_EDGE]),
    .run(run0),
    .mode(ctl0_r[CTL_MODE_LSB +: 2]),
    .freeze(rd_hi0),
    .load(load0),
    .load_value({wdata, low_buf0_r}),
    .preload(preload0_r),
    .count(count0),
    .overflow(ovf0),
    .measure_done(done0)
  );

  timer_unit u_cnt1 (
    .clock(clock),
    .reset(reset),
    .tick(tick1),
    .event_sync(sync2_r[1]),
    .edge_sel(ctl1_r[CTL_EDGE]),
    .run(run1),
    .mode(ctl1_r[CTL_MODE_LSB +: 2]),
    .freeze(rd_hi1),
    .load(load1),
    .load_value({wdata, low_buf1_r}),
    .preload(preload1_r),
    .count(count1),
    .overflow(ovf1),
    .measure_done(done1)
  );

  // ----------------------------------------
  // Register next values
  // ----------------------------------------
  // A software write in the same cycle as a finished measurement wins
  wire [7:0] ctl0_nxt = wr_ctl0 ? {wdata[7:6], 1'b0, wdata[4:0]} :
                        done0 ? (ctl0_r & ~(8'h01 << CTL_RUN)) : ctl0_r;
  wire [7:0] ctl1_nxt = wr_ctl1 ? {wdata[7:3], 3'b000} :
                        done1 ? (ctl1_r & ~(8'h01 << CTL_RUN)) : ctl1_r;
  wire [7:0] low0_nxt = wr_lo0 ? wdata : rd_hi0 ? count0[7:0] : low_buf0_r;
  wire [7:0] low1_nxt = wr_lo1 ? wdata : rd_hi1 ? count1[7:0] : low_buf1_r;
  wire [15:0] pre0_nxt = wr_hi0 ? {wdata, low_buf0_r} : preload0_r;
  wire [15:0] pre1_nxt = wr_hi1 ? {wdata, low_buf1_r} : preload1_r;
  // Hardware set beats a software clear in the same cycle
  wire flag0_nxt = ovf0 | (wr_irq0 ? wdata[IRQ0_FLAG_BIT] : flag0_r);
  wire flag1_nxt = ovf1 | (wr_irq1 ? wdata[IRQ1_FLAG_BIT] : flag1_r);
  wire [3:0] port_nxt = wr_port ? wdata[3:0] : port_r;
  wire sel_ovf = port_r[PA_PFD_SRC] ? ovf1 : ovf0;
  wire pfd_nxt = ~port_r[PA_LATCH] ? 1'b0 : (sel_ovf ? ~pfd_r : pfd_r);
  wire pin_nxt = port_r[PA_PFD_EN] ? (port_r[PA_LATCH] & pfd_r) : port_r[PA_LATCH];
  wire irq_nxt = (flag0_r & irq0_en_r) | (flag1_r & irq1_en_r);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [7:0] irq0_view = {1'b0, flag0_r, 5'h00, irq0_en_r};
  wire [7:0] irq1_view = {3'h0, flag1_r, 3'h0, irq1_en_r};
  wire [7:0] port_view = {3'h0, sync2_r[3], port_r};
  wire [7:0] rd_byte =
    ~aligned ? 8'h00 :
    (idx == IDX_CNT0_HIGH) ? count0[15:8] :
    (idx == IDX_CNT0_LOW) ? low_buf0_r :
    (idx == IDX_CNT0_CONTROL) ? ctl0_r :
    (idx == IDX_CNT1_HIGH) ? count1[15:8] :
    (idx == IDX_CNT1_LOW) ? low_buf1_r :
    (idx == IDX_CNT1_CONTROL) ? ctl1_r :
    (idx == IDX_IRQ_CONTROL0) ? irq0_view :
    (idx == IDX_SECOND_IRQ_CONTROL) ? irq1_view :
    (idx == IDX_PORT_A_CONTROL) ? port_view : 8'h00;

  // ----------------------------------------
  // Bus slave: one wait state per access
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rsp_r.waitrequest <= 1'b1;
      rsp_r.readdata <= 32'h0000_0000;
    end else begin
      rsp_r.waitrequest <= ~acc_go;
      if (rd_go) begin
        rsp_r.readdata <= {24'h000000, rd_byte};
      end
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctl0_r <= CTL_RESET;
      ctl1_r <= CTL_RESET;
      low_buf0_r <= 8'h00;
      low_buf1_r <= 8'h00;
      preload0_r <= COUNT_RESET;
      preload1_r <= COUNT_RESET;
      irq0_en_r <= 1'b0;
      irq1_en_r <= 1'b0;
      flag0_r <= 1'b0;
      flag1_r <= 1'b0;
      port_r <= PA_RESET;
    end else begin
      ctl0_r <= ctl0_nxt;
      ctl1_r <= ctl1_nxt;
      low_buf0_r <= low0_nxt;
      low_buf1_r <= low1_nxt;
      preload0_r <= pre0_nxt;
      preload1_r <= pre1_nxt;
      irq0_en_r <= wr_irq0 ? wdata[IRQ_EN_BIT] : irq0_en_r;
      irq1_en_r <= wr_irq1 ? wdata[IRQ_EN_BIT] : irq1_en_r;
      flag0_r <= flag0_nxt;
      flag1_r <= flag1_nxt;
      port_r <= port_nxt;
    end
  end

  // ----------------------------------------
  // Prescaler, divider pin and events
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      psc_r <= '0;
      pfd_r <= 1'b0;
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
      wake_r <= 1'b0;
      irq_r <= 1'b0;
      pwm_tick_r <= 1'b0;
    end else begin
      psc_r <= PSC_W'(psc_r + 1'b1);
      pfd_r <= pfd_nxt;
      pin_out_r <= pin_nxt;
      pin_oe_r <= ~port_r[PA_INPUT];
      wake_r <= ovf0 | ovf1;
      irq_r <= irq_nxt;
      pwm_tick_r <= tick0;
    end
  end

  assign bus_rsp = rsp_r;
  assign port_a_bit3_out = pin_out_r;
  assign port_a_bit3_oe = pin_oe_r;
  assign wake_up = wake_r;
  assign irq_request = irq_r;
  assign pwm_clock_tick = pwm_tick_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_run_hw_clear: assert property (done1 && !wr_ctl1 |=> !run1)
    else $error("run not cleared after measurement");
  a_run_sw_only: assert property (run0 && ctl0_r[7:6] != MODE_PULSE && !wr_ctl0 |=> run0)
    else $error("run cleared by hardware outside pulse mode");
  a_ovf_reload: assert property (ovf0 && !load0 |=> count0 == $past(preload0_r))
    else $error("counter not reloaded on overflow");
  a_flag_set: assert property (ovf1 |=> flag1_r ##1 irq_r || !irq1_en_r)
    else $error("overflow flag not set");
  a_wake_pulse: assert property (ovf0 || ovf1 |=> wake_up)
    else $error("no wake-up on overflow");
  a_irq_gate: assert property (!irq0_en_r && !irq1_en_r |=> !irq_request)
    else $error("interrupt raised while disabled");
  a_stop_load: assert property (load0 |=> count0 == preload0_r)
    else $error("stopped counter not loaded");
  a_run_no_load: assert property (wr_hi0 && run0 && !ovf0 |=>
      count0 == $past(count0) || count0 == 16'($past(count0) + 16'h0001))
    else $error("running counter jumped on preload write");
  a_read_freeze: assert property (rd_hi1 |=> count1 == $past(count1))
    else $error("counter moved during read");
  a_ctl1_low_zero: assert property (rd_go && idx == IDX_CNT1_CONTROL |=>
      rsp_r.readdata[2:0] == 3'b000)
    else $error("unimplemented bits read nonzero");
  a_pfd_gate: assert property (!port_r[PA_LATCH] |=> !pin_out_r)
    else $error("pin not held low by latch");
  a_pfd_toggle: assert property (port_r[PA_LATCH] && sel_ovf |=> pfd_r != $past(pfd_r))
    else $error("divider did not toggle");
  a_bus_answer: assert property (acc_go |=> !bus_rsp.waitrequest ##1 bus_rsp.waitrequest)
    else $error("bus answer timing wrong");

  c_overflow0: cover property (ovf0);
  c_pulse_done: cover property (done1 ##1 !run1);
  c_pfd_pin: cover property (port_r[PA_PFD_EN] && pin_out_r && pin_oe_r);
endmodule
`default_nettype wire
